// ---- fisu_host_model.sv ----
// host processor model: single-byte register strobes and the interrupt line seen by the host
// assumes the bench calls wr and rd; a board resistor pulls the released line up
`timescale 1ns/1ps
`default_nettype none
module fisu_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // interrupt line
  input wire logic irq_out_n,
  input wire logic irq_out_oe,
  output logic irq_line
);
  // released line floats up through the board resistor
  assign irq_line = irq_out_oe ? irq_out_n : 1'b1;

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // strobe held across one rising edge, bus then shows the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : fisu_host_model
`default_nettype wire

// ---- fisu_pkg.sv ----
// types of the fault and interrupt status unit
// assumes nothing of its surroundings
package fisu_pkg;

  // thermal / current fault recovery
  typedef enum logic [1:0] {
    TH_OK,
    TH_HOLD,
    TH_ARMED
  } fisu_therm_st_t;

endpackage : fisu_pkg

// ---- fisu_regs.svh ----
// register offsets, field positions, reset values and timing counts of the fault and
// interrupt status unit; definitions only, included by the top and retry timer design files of the unit
//
// Operation
// - Active without serial clocks: clock error, shutdown
// - Overtemperature or overcurrent forces software shutdown
// - Thermal/current faults latch; interrupt when unmasked
// - Retry enable: auto restart, else latch until shutdown
// - No restart before retry interval, 1.5 s
// - Shutdown cycle still waits out retry interval
// - Limiter events reported in flags and interrupt
// - Regulator mode: under/over voltage, overload shut down
// - Open-drain interrupt low while unmasked fault present
// - Pull-up bit in 0x04 connects interrupt pull-up
// - Two-bit interrupt configuration field in 0x5C
// - Polarity bit; clear command empties all latches
// - Live flags only in Active or Mute, zero otherwise
// - Latched flags survive shutdown until explicit clear
// - Three unmasked latched clock-error cause flags
// - Supply, limiter, max-atten: live, latch, mask=1
// - Regulator under-voltage latched, mask resets zero
// - Input pull-downs off during hardware shutdown
// - Address zero selects register page 00h-FFh
// - Address one bit 0 requests software reset
// - Software reset restores defaults, bit self-clears
// - Mode 000 active, 001 mute, 010 shutdown
// - Clock errors gone: leave shutdown, resume playback
// - Supply faults hold until shutdown transition
`ifndef FISU_REGS_SVH
`define FISU_REGS_SVH

// offsets (page 0, except the page register which every page holds)
`define FISU_ADDR_PAGE 8'h00
`define FISU_ADDR_SWRST 8'h01
`define FISU_ADDR_MODE 8'h02
`define FISU_ADDR_CFG04 8'h04
`define FISU_ADDR_RETRY 8'h30
`define FISU_ADDR_PULLDN 8'h31
`define FISU_ADDR_MASK_F 8'h32
`define FISU_ADDR_MASK_L 8'h33
`define FISU_ADDR_LAT_F 8'h34
`define FISU_ADDR_LAT_L 8'h35
`define FISU_ADDR_LAT_C 8'h36
`define FISU_ADDR_LIVE_L 8'h37
`define FISU_ADDR_STATUS 8'h38
`define FISU_ADDR_IRQCFG 8'h5c

// reset values
`define FISU_RST_PAGE 8'h00
`define FISU_RST_MODE_REG 8'h1a
`define FISU_RST_CFG04 8'h21
`define FISU_RST_MASK_F 6'h04
`define FISU_RST_MASK_L 5'h07

// fields
`define FISU_MODE_ACTIVE 3'h0
`define FISU_MODE_MUTE 3'h1
`define FISU_MODE_SHUTDOWN 3'h2
`define FISU_PULLUP_BIT 6
`define FISU_IRQCFG_POL_BIT 2
`define FISU_IRQCFG_CLR_BIT 3
`define FISU_IRQCFG_PUSHPULL 2'h1
// fault vector bits: ot, oc, clock, reg uv, reg ov, reg overload
`define FISU_F_OT 0
`define FISU_F_OC 1
`define FISU_F_CLK 2
`define FISU_F_UV 3
`define FISU_F_OV 4
`define FISU_F_OL 5

// timing
`define FISU_CLK_HZ 25000000
`define FISU_RETRY_TIME_MS 1500
`define FISU_RETRY_CYCLES (`FISU_RETRY_TIME_MS * (`FISU_CLK_HZ / 1000))
`define FISU_TMR_W 26

`endif

// ---- fisu_retry_timer.sv ----
// retry interval timer: start reloads, done is high once the interval has run out
// assumes start is a level on core_clk; each high cycle reloads the count
`timescale 1ns/1ps
`default_nettype none
`include "fisu_regs.svh"
module fisu_retry_timer #(
  parameter int unsigned CYCLES = `FISU_RETRY_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  output logic done
);

  localparam logic [`FISU_TMR_W-1:0] LOAD = `FISU_TMR_W'(CYCLES - 1);

  logic [`FISU_TMR_W-1:0] cnt_q;
  logic [`FISU_TMR_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (start) begin
      cnt_d = LOAD;
      busy_d = 1'b1;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - `FISU_TMR_W'(1);
    end else begin
      busy_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign done = !busy_q;

endmodule : fisu_retry_timer
`default_nettype wire

// ---- fisu_sync.sv ----
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level, not a multi-bit word
`timescale 1ns/1ps
`default_nettype none
module fisu_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : fisu_sync
`default_nettype wire

// ---- fisu_top.sv ----
// fault supervision and interrupt reporting: fault shutdown, retry, flags, interrupt pin
// assumes a host front-end (i2c/spi) on core_clk giving single-cycle register strobes;
// monitor and pin inputs are asynchronous levels
`timescale 1ns/1ps
`default_nettype none
`include "fisu_regs.svh"
module fisu_top #(
  parameter int unsigned RETRY_CYCLES = `FISU_RETRY_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port from the host interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic shutdown_n_pin,
  output logic irq_out_n,
  output logic irq_out_oe,
  output logic irq_pullup_en,
  output logic [4:0] input_pulldown_en,
  // serial clock monitor
  input wire logic clocks_absent,
  input wire logic clock_ratio_invalid,
  input wire logic frame_rate_change,
  input wire logic ratio_change,
  // analog monitors
  input wire logic overtemp,
  input wire logic overcurrent,
  input wire logic regulator_undervolt,
  input wire logic regulator_overvolt,
  input wire logic regulator_overload,
  // limiter: engaged, below inflection, max atten, infinite hold, mute
  input wire logic [4:0] limiter_event,
  // amplifier control
  output logic amp_enable,
  output logic amp_mute,
  output logic fault_shutdown
);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  logic [14:0] in_s;
  logic sdz_s;
  logic [3:0] clk_s;
  logic ot_s;
  logic oc_s;
  logic [2:0] regf_s;
  logic [4:0] lim_s;

  fisu_sync #(.W(15)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_i({shutdown_n_pin, clocks_absent, clock_ratio_invalid, frame_rate_change,
              ratio_change, overtemp, overcurrent, regulator_undervolt,
              regulator_overvolt, regulator_overload, limiter_event}),
    .sync_o(in_s)
  );

  assign sdz_s = in_s[14];
  assign clk_s = in_s[13:10];
  assign ot_s = in_s[9];
  assign oc_s = in_s[8];
  assign regf_s = in_s[7:5];
  assign lim_s = in_s[4:0];

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] page_q, page_d;
  logic swrst_q, swrst_d;
  logic [7:0] mode_reg_q, mode_reg_d;
  logic [7:0] cfg04_q, cfg04_d;
  logic [2:0] retry_q, retry_d;
  logic [4:0] pulldn_q, pulldn_d;
  logic [5:0] mask_f_q, mask_f_d;
  logic [4:0] mask_l_q, mask_l_d;
  logic [1:0] irq_cfg_q, irq_cfg_d;
  logic irq_pol_q, irq_pol_d;
  logic irq_clr_q, irq_clr_d;
  logic [7:0] rdata_d;
  logic wr_p0;
  logic [2:0] mode;

  assign wr_p0 = reg_wr && (page_q == 8'h00);
  assign mode = mode_reg_q[2:0];

  always_comb begin
    page_d = page_q;
    swrst_d = 1'b0;
    mode_reg_d = mode_reg_q;
    cfg04_d = cfg04_q;
    retry_d = retry_q;
    pulldn_d = pulldn_q;
    mask_f_d = mask_f_q;
    mask_l_d = mask_l_q;
    irq_cfg_d = irq_cfg_q;
    irq_pol_d = irq_pol_q;
    irq_clr_d = 1'b0;
    if (swrst_q) begin
      page_d = `FISU_RST_PAGE;
      mode_reg_d = `FISU_RST_MODE_REG;
      cfg04_d = `FISU_RST_CFG04;
      retry_d = '0;
      pulldn_d = '0;
      mask_f_d = `FISU_RST_MASK_F;
      mask_l_d = `FISU_RST_MASK_L;
      irq_cfg_d = '0;
      irq_pol_d = 1'b0;
    end else if (reg_wr && reg_addr == `FISU_ADDR_PAGE) begin
      page_d = reg_wdata;
    end else if (wr_p0) begin
      case (reg_addr)
        `FISU_ADDR_SWRST: swrst_d = reg_wdata[0];
        `FISU_ADDR_MODE: mode_reg_d = reg_wdata;
        `FISU_ADDR_CFG04: cfg04_d = reg_wdata;
        `FISU_ADDR_RETRY: retry_d = reg_wdata[2:0];
        `FISU_ADDR_PULLDN: pulldn_d = reg_wdata[4:0];
        `FISU_ADDR_MASK_F: mask_f_d = reg_wdata[5:0];
        `FISU_ADDR_MASK_L: mask_l_d = reg_wdata[4:0];
        `FISU_ADDR_IRQCFG: begin
          irq_cfg_d = reg_wdata[1:0];
          irq_pol_d = reg_wdata[`FISU_IRQCFG_POL_BIT];
          irq_clr_d = reg_wdata[`FISU_IRQCFG_CLR_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= `FISU_RST_PAGE;
      swrst_q <= 1'b0;
      mode_reg_q <= `FISU_RST_MODE_REG;
      cfg04_q <= `FISU_RST_CFG04;
      retry_q <= '0;
      pulldn_q <= '0;
      mask_f_q <= `FISU_RST_MASK_F;
      mask_l_q <= `FISU_RST_MASK_L;
      irq_cfg_q <= '0;
      irq_pol_q <= 1'b0;
      irq_clr_q <= 1'b0;
    end else begin
      page_q <= page_d;
      swrst_q <= swrst_d;
      mode_reg_q <= mode_reg_d;
      cfg04_q <= cfg04_d;
      retry_q <= retry_d;
      pulldn_q <= pulldn_d;
      mask_f_q <= mask_f_d;
      mask_l_q <= mask_l_d;
      irq_cfg_q <= irq_cfg_d;
      irq_pol_q <= irq_pol_d;
      irq_clr_q <= irq_clr_d;
    end
  end

  soft_reset_a: assert property (swrst_q |=> mode == `FISU_MODE_SHUTDOWN && page_q == 8'h00
    && mask_l_q == `FISU_RST_MASK_L) else $error("soft reset left a register set");

  ////////////////////////////////////////////////////////////////////////////////
  // fault supervision

  logic overtemp_autoretry_en;
  logic overcurrent_autoretry_en;
  logic internal_regulator_power_mode;
  logic host_sd, active_req, clk_fault, reg_fault, therm_ev;
  logic tmr_done;
  fisu_pkg::fisu_therm_st_t th_q, th_d;
  logic ot_cause_q, ot_cause_d, oc_cause_q, oc_cause_d;
  logic reg_lock_q, reg_lock_d;
  logic run_q, run_d;
  logic retry_ok;

  assign overtemp_autoretry_en = retry_q[0];
  assign overcurrent_autoretry_en = retry_q[1];
  assign internal_regulator_power_mode = retry_q[2];
  assign host_sd = (mode == `FISU_MODE_SHUTDOWN) || !sdz_s;
  assign active_req = sdz_s && (mode == `FISU_MODE_ACTIVE || mode == `FISU_MODE_MUTE);
  assign clk_fault = |clk_s;
  assign reg_fault = internal_regulator_power_mode && (|regf_s);
  assign therm_ev = active_req && (ot_s || oc_s);
  assign retry_ok = (!ot_cause_q || overtemp_autoretry_en)
                    && (!oc_cause_q || overcurrent_autoretry_en);

  fisu_retry_timer #(.CYCLES(RETRY_CYCLES)) u_retry (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(therm_ev),
    .done(tmr_done)
  );

  always_comb begin
    th_d = th_q;
    ot_cause_d = ot_cause_q;
    oc_cause_d = oc_cause_q;
    reg_lock_d = reg_lock_q;
    case (th_q)
      fisu_pkg::TH_OK: begin
        ot_cause_d = 1'b0;
        oc_cause_d = 1'b0;
      end
      fisu_pkg::TH_HOLD: if (retry_ok || host_sd) th_d = fisu_pkg::TH_ARMED;
      fisu_pkg::TH_ARMED: if (tmr_done && !ot_s && !oc_s) th_d = fisu_pkg::TH_OK;
      default: th_d = fisu_pkg::TH_OK;
    endcase
    if (therm_ev) begin
      th_d = fisu_pkg::TH_HOLD;
      ot_cause_d = (th_q != fisu_pkg::TH_OK && ot_cause_q) || ot_s;
      oc_cause_d = (th_q != fisu_pkg::TH_OK && oc_cause_q) || oc_s;
    end
    if (reg_fault) begin
      reg_lock_d = 1'b1;
    end else if (host_sd) begin
      reg_lock_d = 1'b0;
    end
    // clock faults hold only while present, so playback resumes once they clear
    run_d = active_req && !clk_fault && !reg_fault && !reg_lock_q && !therm_ev
            && th_q == fisu_pkg::TH_OK;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      th_q <= fisu_pkg::TH_OK;
      ot_cause_q <= 1'b0;
      oc_cause_q <= 1'b0;
      reg_lock_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      th_q <= th_d;
      ot_cause_q <= ot_cause_d;
      oc_cause_q <= oc_cause_d;
      reg_lock_q <= reg_lock_d;
      run_q <= run_d;
    end
  end

  clk_err_sd_a: assert property (active_req && clk_fault |=> !run_q)
    else $error("amplifier ran with a serial clock error");
  therm_sd_a: assert property (therm_ev |=> !run_q [*2])
    else $error("amplifier ran after a thermal or current fault");
  retry_wait_a: assert property (th_q != fisu_pkg::TH_OK && !tmr_done |=> !run_q)
    else $error("restart before retry interval");
  latch_hold_a: assert property (th_q == fisu_pkg::TH_HOLD && !retry_ok && !host_sd
    && !therm_ev |=> th_q == fisu_pkg::TH_HOLD)
    else $error("latching fault released without shutdown cycle");
  reg_hold_a: assert property (reg_lock_q && !host_sd |=> reg_lock_q)
    else $error("regulator fault released without shutdown");

  ////////////////////////////////////////////////////////////////////////////////
  // live and latched flags

  logic [5:0] lat_f_q, lat_f_d, set_f;
  logic [4:0] lat_l_q, lat_l_d;
  logic [2:0] lat_c_q, lat_c_d;
  logic [4:0] live_q, live_d;
  logic clr_all;

  assign clr_all = irq_clr_q || swrst_q;

  always_comb begin
    set_f = '0;
    set_f[`FISU_F_OT] = active_req && ot_s;
    set_f[`FISU_F_OC] = active_req && oc_s;
    set_f[`FISU_F_CLK] = active_req && clk_fault;
    set_f[`FISU_F_UV] = internal_regulator_power_mode && regf_s[2];
    set_f[`FISU_F_OV] = internal_regulator_power_mode && regf_s[1];
    set_f[`FISU_F_OL] = internal_regulator_power_mode && regf_s[0];
    live_d = lim_s & {5{run_d}};
    // a new event wins over a clear in the same cycle
    lat_f_d = (clr_all ? 6'h00 : lat_f_q) | set_f;
    lat_l_d = (clr_all ? 5'h00 : lat_l_q) | live_d;
    // cause bits: [0] ratio invalid, [1] rate changed, [2] ratio changed
    lat_c_d = (clr_all ? 3'h0 : lat_c_q) | ({3{active_req}} & {clk_s[0], clk_s[1], clk_s[2]});
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_f_q <= '0;
      lat_l_q <= '0;
      lat_c_q <= '0;
      live_q <= '0;
    end else begin
      lat_f_q <= lat_f_d;
      lat_l_q <= lat_l_d;
      lat_c_q <= lat_c_d;
      live_q <= live_d;
    end
  end

  live_zero_a: assert property (!run_q |-> live_q == 5'h00)
    else $error("live flag set outside active operation");
  latch_keep_a: assert property (!$past(clr_all) |-> (($past(lat_f_q) & ~lat_f_q) == 6'h00
    && ($past(lat_l_q) & ~lat_l_q) == 5'h00)) else $error("latched flag lost");
  clear_all_a: assert property (irq_clr_q && set_f == 6'h00 && live_d == 5'h00
    && !(active_req && clk_fault) |=> lat_f_q == 6'h00 && lat_l_q == 5'h00
    && lat_c_q == 3'h0) else $error("clear left a latched flag");

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt pin, pull controls and amplifier outputs

  logic irq_act;
  logic irq_lvl;
  logic [7:0] status;

  assign irq_act = (|(lat_f_q & ~mask_f_q)) || (|(lat_l_q & ~mask_l_q));
  assign irq_lvl = irq_act ? irq_pol_q : !irq_pol_q;
  assign status = {5'h00, th_q != fisu_pkg::TH_OK, active_req && !run_q, run_q};

  always_comb begin
    rdata_d = reg_rdata;
    if (reg_rd) begin
      rdata_d = 8'h00;
      if (reg_addr == `FISU_ADDR_PAGE) begin
        rdata_d = page_q;
      end else if (page_q == 8'h00) begin
        case (reg_addr)
          `FISU_ADDR_SWRST: rdata_d = {7'h00, swrst_q};
          `FISU_ADDR_MODE: rdata_d = mode_reg_q;
          `FISU_ADDR_CFG04: rdata_d = cfg04_q;
          `FISU_ADDR_RETRY: rdata_d = {5'h00, retry_q};
          `FISU_ADDR_PULLDN: rdata_d = {3'h0, pulldn_q};
          `FISU_ADDR_MASK_F: rdata_d = {2'h0, mask_f_q};
          `FISU_ADDR_MASK_L: rdata_d = {3'h0, mask_l_q};
          `FISU_ADDR_LAT_F: rdata_d = {2'h0, lat_f_q};
          `FISU_ADDR_LAT_L: rdata_d = {3'h0, lat_l_q};
          `FISU_ADDR_LAT_C: rdata_d = {5'h00, lat_c_q};
          `FISU_ADDR_LIVE_L: rdata_d = {3'h0, live_q};
          `FISU_ADDR_STATUS: rdata_d = status;
          `FISU_ADDR_IRQCFG: rdata_d = {5'h00, irq_pol_q, irq_cfg_q};
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      irq_out_n <= 1'b1;
      irq_out_oe <= 1'b0;
      irq_pullup_en <= 1'b0;
      input_pulldown_en <= 5'h00;
      amp_enable <= 1'b0;
      amp_mute <= 1'b0;
      fault_shutdown <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      irq_out_n <= irq_lvl;
      // open drain only pulls low; push-pull drives both levels
      irq_out_oe <= (irq_cfg_q == `FISU_IRQCFG_PUSHPULL) || !irq_lvl;
      irq_pullup_en <= cfg04_q[`FISU_PULLUP_BIT];
      input_pulldown_en <= pulldn_q & {5{sdz_s}};
      amp_enable <= run_q;
      amp_mute <= run_q && mode == `FISU_MODE_MUTE;
      fault_shutdown <= active_req && !run_q;
    end
  end

  irq_od_a: assert property (irq_act && !irq_pol_q |=> !irq_out_n && irq_out_oe)
    else $error("interrupt pin not pulled low for unmasked fault");
  irq_mask_a: assert property (lat_f_q[`FISU_F_OT] && mask_f_q[`FISU_F_OT] == 1'b0
    |=> irq_out_n == $past(irq_pol_q)) else $error("unmasked overtemp not signalled");
  pulldn_off_a: assert property (!sdz_s |=> input_pulldown_en == 5'h00)
    else $error("pull-downs on in hardware shutdown");

endmodule : fisu_top
`default_nettype wire

// ---- test_fault_interrupt_status_unit.sv ----
// self-checking bench of the fault and interrupt status unit against a register model
// assumes fisu_top with a short retry interval and the host model beside it
`timescale 1ns/1ps
`default_nettype none
module test_fault_interrupt_status_unit;
  localparam int RC = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic shutdown_n_pin = 1'b1;
  logic clocks_absent = 1'b0;
  logic overtemp = 1'b0;
  logic overcurrent = 1'b0;
  logic [2:0] clk_cause = 3'h0;
  logic [2:0] reg_flt = 3'h0;
  logic [4:0] limiter_event = 5'h00;
  logic [4:0] ev;
  logic reg_wr, reg_rd, irq_out_n, irq_out_oe, irq_pullup_en, irq_line;
  logic amp_enable, amp_mute, fault_shutdown;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [4:0] input_pulldown_en;
  int miscompares = 0;
  int cmp_count = 0;
  int seed = 77;
  int tick = 0;
  int t0;
  int mdl [0:255];
  int ra[$] = '{'h00, 'h01, 'h02, 'h04, 'h30, 'h31, 'h32, 'h33, 'h34, 'h35, 'h36, 'h10};

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) tick <= tick + 1;

  fisu_top #(.RETRY_CYCLES(RC)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .shutdown_n_pin(shutdown_n_pin), .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe),
    .irq_pullup_en(irq_pullup_en), .input_pulldown_en(input_pulldown_en),
    .clocks_absent(clocks_absent), .clock_ratio_invalid(clk_cause[0]),
    .frame_rate_change(clk_cause[1]), .ratio_change(clk_cause[2]), .overtemp(overtemp),
    .overcurrent(overcurrent), .regulator_undervolt(reg_flt[0]),
    .regulator_overvolt(reg_flt[1]), .regulator_overload(reg_flt[2]),
    .limiter_event(limiter_event), .amp_enable(amp_enable), .amp_mute(amp_mute),
    .fault_shutdown(fault_shutdown));

  fisu_host_model host (
    .core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n),
    .irq_out_oe(irq_out_oe), .irq_line(irq_line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic void mdl_init();
    foreach (mdl[i]) mdl[i] = 0;
    mdl[2] = 'h1a;
    mdl[4] = 'h21;
    mdl['h32] = 'h04;
    mdl['h33] = 'h07;
  endfunction : mdl_init

  task automatic w(input int a, input int d);
    host.wr(8'(a), 8'(d));
    mdl[a] = d;
  endtask : w

  task automatic r(input int a);
    host.rd(8'(a), rv);
    chk(rv, 8'(mdl[a]));
  endtask : r

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  // bounded wait for the output stage to reach a level
  task automatic wamp(input logic v);
    for (int c = 0; c < 200 && amp_enable !== v; c++) @(negedge core_clk);
  endtask : wamp

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    miscompares++;
    stop_test();
  end

  initial begin
    mdl_init();
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    foreach (ra[i]) r(ra[i]);
    chk(8'(irq_line), 8'h01);
    $display("test reset values done");
    w(0, ($random(seed) & 'hfe) | 'h02);
    r(0);
    host.rd(8'h02, rv);
    chk(rv, 8'h00);
    w(0, 0);
    r(2);
    w(4, 'h61);
    cyc(2);
    chk(8'(irq_pullup_en), 8'h01);
    w(1, 1);
    cyc(3);
    mdl_init();
    foreach (ra[i]) r(ra[i]);
    chk(8'(irq_pullup_en), 8'h00);
    $display("test paging and soft reset done");
    w(2, 'h19);
    wamp(1'b1);
    chk({6'h0, amp_mute, amp_enable}, 8'h03);
    w(2, 'h1a);
    wamp(1'b0);
    chk(8'(amp_enable), 8'h00);
    clocks_absent = 1'b1;
    clk_cause = 3'h3;
    w(2, 'h18);
    cyc(8);
    chk({6'h0, fault_shutdown, amp_enable}, 8'h02);
    chk(8'(irq_line), 8'h01);
    mdl['h34] = 4;
    mdl['h36] = 3;
    mdl['h38] = 2;
    r('h34);
    r('h36);
    r('h38);
    clocks_absent = 1'b0;
    clk_cause = 3'h0;
    wamp(1'b1);
    chk(8'(amp_enable), 8'h01);
    $display("test clock error done");
    ev = 5'($random(seed)) | 5'h01;
    limiter_event = ev;
    cyc(4);
    mdl['h37] = ev;
    mdl['h35] = ev;
    r('h37);
    r('h35);
    chk(8'(irq_line), 8'(!(ev & 5'h18)));
    w('h33, 0);
    cyc(3);
    chk(8'(irq_line), 8'h00);
    limiter_event = 5'h00;
    w('h5c, 8);
    cyc(4);
    mdl['h34] = 0;
    mdl['h35] = 0;
    mdl['h36] = 0;
    r('h35);
    r('h34);
    r('h36);
    chk(8'(irq_line), 8'h01);
    w('h33, 7);
    w(2, 'h1a);
    wamp(1'b0);
    limiter_event = 5'h1f;
    cyc(4);
    mdl['h37] = 0;
    r('h37);
    limiter_event = 5'h00;
    $display("test limiter flags done");
    w(2, 'h18);
    wamp(1'b1);
    t0 = tick;
    overtemp = 1'b1;
    cyc(3);
    overtemp = 1'b0;
    cyc(3);
    chk(8'(amp_enable), 8'h00);
    chk(8'(irq_line), 8'h00);
    w(2, 'h1a);
    mdl['h34] = 1;
    r('h34);
    w(2, 'h18);
    wamp(1'b1);
    chk(8'(tick - t0 >= RC), 8'h01);
    chk(8'(amp_enable), 8'h01);
    w('h5c, 8);
    overcurrent = 1'b1;
    cyc(3);
    overcurrent = 1'b0;
    cyc(2 * RC + 10);
    chk(8'(amp_enable), 8'h00);
    mdl['h34] = 2;
    r('h34);
    w('h5c, 8);
    w(2, 'h1a);
    w(2, 'h18);
    wamp(1'b1);
    chk(8'(amp_enable), 8'h01);
    w('h30, 2);
    t0 = tick;
    overcurrent = 1'b1;
    cyc(3);
    overcurrent = 1'b0;
    cyc(3);
    chk(8'(amp_enable), 8'h00);
    wamp(1'b1);
    chk(8'(amp_enable), 8'h01);
    chk(8'(tick - t0 >= RC), 8'h01);
    w('h5c, 8);
    $display("test thermal and current faults done");
    w('h30, 4);
    for (int k = 0; k < 3; k++) begin
      w(2, 'h1a);
      w(2, 'h18);
      wamp(1'b1);
      reg_flt = 3'(1 << k);
      cyc(6);
      reg_flt = 3'h0;
      cyc(10);
      chk(8'(amp_enable), 8'h00);
      chk(8'(irq_line), 8'h00);
      mdl['h34] = 8 << k;
      r('h34);
      w('h5c, 8);
    end
    w(2, 'h1a);
    $display("test regulator faults done");
    w('h5c, 4);
    cyc(3);
    chk(8'(irq_out_n), 8'h00);
    w('h5c, 1);
    cyc(3);
    chk(8'(irq_out_oe), 8'h01);
    w('h5c, 0);
    cyc(3);
    chk({6'h0, irq_out_oe, irq_line}, 8'h01);
    w('h31, 'h1f);
    cyc(2);
    chk(8'(input_pulldown_en), 8'h1f);
    shutdown_n_pin = 1'b0;
    cyc(4);
    chk(8'(input_pulldown_en), 8'h00);
    shutdown_n_pin = 1'b1;
    $display("test pin configuration done");
    stop_test();
  end
endmodule : test_fault_interrupt_status_unit
`default_nettype wire
